// ### src/brg_top.sv
// Baud rate generator with APB register access and receive-pin voter.
// Assumes APB master at the system clock; rx synchronous to clock.
`timescale 1ns/1ps
// How it works
// - One divider, 8 or 16 bits, both modes
// - Reset to 8-bit; wide select widens
// - Divisor pair sets free-running timer period
// - High-speed matters only in asynchronous mode
// - Factors 64, 16 and 4 per mode
// - Bit clock driven only in master mode
// - Divisor write clears the timer at once
// - Counts on system clock, rate follows it
// - Receive pin majority of three samples
module brg_top
   import brg_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // APB
   input wire brg_pkg::brg_apb_req_s apb_req,
   output brg_pkg::brg_apb_rsp_s apb_rsp,
   // Serial side
   input wire logic rx,
   output logic baud_tick_ff,
   output logic bit_clock_ff,
   output logic rx_bit_ff,
   output logic rx_bit_valid_ff
);
   import brg_pkg::*;

   logic [7:0] baud_control_ff;
   logic [7:0] transmit_control_ff;
   logic [7:0] divisor_low_byte_ff;
   logic [7:0] divisor_high_byte_ff;
   logic [15:0] rate_divider_ff;
   logic [5:0] prescale_ff;
   logic [5:0] nxt_prescale_max;
   logic [15:0] divisor;
   logic wide_divider_select;
   logic high_speed_select;
   logic sync_mode;
   logic master_mode;
   logic access;
   logic wr;
   logic div_write;
   logic timer_end;
   logic pre_end;
   logic [1:0] sample_ff;
   logic [31:0] rdata;
   logic vote_bit;
   logic vote_valid;

   assign access = apb_req.psel && apb_req.penable;
   assign wr = access && apb_req.pwrite;
   assign div_write = wr && (apb_req.paddr == ADDR_DIVISOR_LOW || apb_req.paddr == ADDR_DIVISOR_HIGH);

   assign wide_divider_select = baud_control_ff[WIDE_BIT];
   assign high_speed_select = transmit_control_ff[HIGH_SPEED_BIT];
   assign sync_mode = transmit_control_ff[SYNC_BIT];
   assign master_mode = transmit_control_ff[MASTER_BIT];
   // Upper byte ignored in narrow width
   assign divisor = wide_divider_select ? {divisor_high_byte_ff, divisor_low_byte_ff}
                                        : {8'h00, divisor_low_byte_ff};

   // Prescale choice per mode
   always_comb begin
      if (sync_mode) begin
         nxt_prescale_max = PRESCALE_4;
      end else begin
         case ({wide_divider_select, high_speed_select})
            2'b00: nxt_prescale_max = PRESCALE_64;
            2'b10: nxt_prescale_max = PRESCALE_16;
            2'b01: nxt_prescale_max = PRESCALE_16;
            2'b11: nxt_prescale_max = PRESCALE_4;
            default: nxt_prescale_max = PRESCALE_64;
         endcase
      end
   end

   // Registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         baud_control_ff <= BAUD_CONTROL_RST;
         transmit_control_ff <= TRANSMIT_CONTROL_RST;
         divisor_low_byte_ff <= DIVISOR_RST;
         divisor_high_byte_ff <= DIVISOR_RST;
      end else if (wr) begin
         case (apb_req.paddr)
            ADDR_BAUD_CONTROL: baud_control_ff <= apb_req.pwdata[7:0] & BAUD_CONTROL_MASK;
            ADDR_TRANSMIT_CONTROL: transmit_control_ff <= apb_req.pwdata[7:0] & TRANSMIT_CONTROL_MASK;
            ADDR_DIVISOR_LOW: divisor_low_byte_ff <= apb_req.pwdata[7:0];
            ADDR_DIVISOR_HIGH: divisor_high_byte_ff <= apb_req.pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Prescaler counts every system clock; divider steps only when the prescaler ends
   assign pre_end = (prescale_ff >= nxt_prescale_max);
   assign timer_end = pre_end && (rate_divider_ff == 16'h0000);

   always_ff @(posedge clock) begin
      if (!rst_n || div_write) begin
         prescale_ff <= 6'h00;
      end else if (pre_end) begin
         prescale_ff <= 6'h00;
      end else begin
         prescale_ff <= prescale_ff + 6'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rate_divider_ff <= 16'h0000;
      end else if (div_write) begin
         rate_divider_ff <= wide_divider_select ? {divisor_high_byte_ff, divisor_low_byte_ff}
                                                : {8'h00, divisor_low_byte_ff};
         if (apb_req.paddr == ADDR_DIVISOR_LOW) begin
            rate_divider_ff[7:0] <= apb_req.pwdata[7:0];
         end else if (wide_divider_select) begin
            rate_divider_ff[15:8] <= apb_req.pwdata[7:0];
         end
      end else if (pre_end) begin
         if (rate_divider_ff == 16'h0000) begin
            rate_divider_ff <= divisor;
         end else begin
            rate_divider_ff <= rate_divider_ff - 16'h0001;
         end
      end
   end

   // Tick and bit clock output
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         baud_tick_ff <= 1'b0;
         bit_clock_ff <= 1'b0;
      end else begin
         baud_tick_ff <= timer_end && !div_write;
         if (!master_mode) begin
            bit_clock_ff <= 1'b0;
         end else if (timer_end && !div_write) begin
            bit_clock_ff <= 1'b1;
         end else begin
            bit_clock_ff <= 1'b0;
         end
      end
   end

   // Three samples spread over each bit period
   always_ff @(posedge clock) begin
      if (!rst_n || div_write) begin
         sample_ff <= 2'h0;
      end else if (timer_end) begin
         sample_ff <= (sample_ff == VOTE_SAMPLES) ? 2'h0 : sample_ff + 2'h1;
      end
   end

   brg_vote u_vote (
      .clock(clock),
      .rst_n(rst_n),
      .sample(timer_end && (sample_ff != 2'h0) && !div_write),
      .clear(div_write),
      .rx(rx),
      .bit_value_ff(vote_bit),
      .bit_valid_ff(vote_valid)
   );

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_bit_ff <= 1'b1;
         rx_bit_valid_ff <= 1'b0;
      end else begin
         rx_bit_ff <= vote_bit;
         rx_bit_valid_ff <= vote_valid;
      end
   end

   // Read mux
   always_comb begin
      rdata = 32'h0000_0000;
      case (apb_req.paddr)
         ADDR_BAUD_CONTROL: rdata = {24'h000000, baud_control_ff};
         ADDR_TRANSMIT_CONTROL: rdata = {24'h000000, transmit_control_ff};
         ADDR_DIVISOR_LOW: rdata = {24'h000000, divisor_low_byte_ff};
         ADDR_DIVISOR_HIGH: rdata = {24'h000000, divisor_high_byte_ff};
         ADDR_STATUS: rdata = {16'h0000, rate_divider_ff};
         default: rdata = 32'h0000_0000;
      endcase
   end

   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = access && !(apb_req.paddr == ADDR_BAUD_CONTROL ||
      apb_req.paddr == ADDR_TRANSMIT_CONTROL || apb_req.paddr == ADDR_DIVISOR_LOW ||
      apb_req.paddr == ADDR_DIVISOR_HIGH || apb_req.paddr == ADDR_STATUS);
   assign apb_rsp.prdata = access ? rdata : 32'h0000_0000;
endmodule

// ### src/brg_pkg.sv
// Package for the baud rate generator: register map, fields, reset values.
// Assumes a 32-bit APB slave with byte addresses; 8-bit registers and the 16-bit status in low bits.
package brg_pkg;
   localparam logic [11:0] ADDR_BAUD_CONTROL = 12'h000;
   localparam logic [11:0] ADDR_TRANSMIT_CONTROL = 12'h004;
   localparam logic [11:0] ADDR_DIVISOR_LOW = 12'h008;
   localparam logic [11:0] ADDR_DIVISOR_HIGH = 12'h00c;
   localparam logic [11:0] ADDR_STATUS = 12'h010;
   localparam int WIDE_BIT = 3;
   localparam int HIGH_SPEED_BIT = 2;
   localparam int SYNC_BIT = 4;
   localparam int MASTER_BIT = 7;
   localparam logic [7:0] BAUD_CONTROL_RST = 8'h00;
   localparam logic [7:0] BAUD_CONTROL_MASK = 8'h08;
   localparam logic [7:0] TRANSMIT_CONTROL_RST = 8'h00;
   localparam logic [7:0] TRANSMIT_CONTROL_MASK = 8'h94;
   localparam logic [7:0] DIVISOR_RST = 8'h00;
   localparam logic [5:0] PRESCALE_64 = 6'h3f;
   localparam logic [5:0] PRESCALE_16 = 6'h0f;
   localparam logic [5:0] PRESCALE_4 = 6'h03;
   localparam logic [1:0] VOTE_SAMPLES = 2'h3;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } brg_apb_req_s;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } brg_apb_rsp_s;
endpackage

// ### src/brg_vote.sv
// Three-sample majority voter for the receive pin.
// Assumes rx is synchronous to clock; sample strobe comes from the divider.
`timescale 1ns/1ps
module brg_vote (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Sampling
   input wire logic sample,
   input wire logic clear,
   input wire logic rx,
   // Result
   output logic bit_value_ff,
   output logic bit_valid_ff
);
   logic [1:0] count_ff;
   logic [1:0] ones_ff;
   logic [1:0] nxt_ones;

   assign nxt_ones = ones_ff + {1'b0, rx};

   always_ff @(posedge clock) begin
      if (!rst_n || clear) begin
         count_ff <= 2'h0;
         ones_ff <= 2'h0;
      end else if (sample) begin
         if (count_ff == 2'h2) begin
            count_ff <= 2'h0;
            ones_ff <= 2'h0;
         end else begin
            count_ff <= count_ff + 2'h1;
            ones_ff <= nxt_ones;
         end
      end
   end

   // Decide on the third sample
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bit_value_ff <= 1'b1;
         bit_valid_ff <= 1'b0;
      end else begin
         bit_valid_ff <= sample && (count_ff == 2'h2);
         if (sample && (count_ff == 2'h2)) begin
            bit_value_ff <= (nxt_ones >= 2'h2);
         end
      end
   end
endmodule

// ### tb/brg_monitor.sv
// Checker on brg_top ports: tick period, bit clock, voter, errors.
// Assumes writes land when psel, penable and pwrite are high.
`timescale 1ns/1ps
module brg_monitor
   import brg_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // APB
   input wire brg_pkg::brg_apb_req_s apb_req,
   input wire brg_pkg::brg_apb_rsp_s apb_rsp,
   // Serial side
   input wire logic rx,
   input wire logic baud_tick_ff,
   input wire logic bit_clock_ff,
   input wire logic rx_bit_ff,
   input wire logic rx_bit_valid_ff
);
   logic [7:0] sh_ff [4];
   logic [23:0] cnt_ff, per;
   logic ok_ff, wr;
   assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
   // Expected clocks per tick
   assign per = (sh_ff[1][SYNC_BIT] ? 24'h4 : (sh_ff[0][WIDE_BIT] ^ sh_ff[1][HIGH_SPEED_BIT]) ? 24'h10
      : sh_ff[0][WIDE_BIT] ? 24'h4 : 24'h40)
      * ((sh_ff[0][WIDE_BIT] ? {8'h0, sh_ff[3], sh_ff[2]} : {16'h0, sh_ff[2]}) + 24'h1);
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sh_ff <= '{default: 8'h0};
      end else if (wr && apb_req.paddr[11:4] == 8'h0 && apb_req.paddr[1:0] == 2'h0) begin
         sh_ff[apb_req.paddr[3:2]] <= apb_req.pwdata[7:0];
      end
   end
   // Period only trusted between two ticks with no write
   always_ff @(posedge clock) begin
      cnt_ff <= (!rst_n || baud_tick_ff) ? 24'h1 : cnt_ff + 24'h1;
      ok_ff <= rst_n && !wr && (ok_ff || baud_tick_ff);
   end
   // Cycles since the last divisor write, and no other write or tick since
   logic fresh_ff, dw;
   logic [23:0] wc_ff;
   assign dw = wr && (apb_req.paddr == ADDR_DIVISOR_LOW || apb_req.paddr == ADDR_DIVISOR_HIGH);
   always_ff @(posedge clock) begin
      wc_ff <= (!rst_n || dw) ? 24'h1 : wc_ff + 24'h1;
      fresh_ff <= rst_n && (dw || (fresh_ff && !wr && !baud_tick_ff));
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_div_write;
      dw;
   endsequence
   sequence s_first_tick;
      baud_tick_ff && fresh_ff;
   endsequence
   a_write_quiet: assert property (s_div_write |=> !baud_tick_ff)
      else $error("tick right after divisor write");
   a_write_restart: assert property (s_first_tick |-> wc_ff == per + 24'h1)
      else $error("timer not restarted by divisor write");
   a_tick_period: assert property (baud_tick_ff && ok_ff |-> cnt_ff == per)
      else $error("tick period wrong");
   a_tick_late: assert property (!(ok_ff && cnt_ff > per))
      else $error("tick missing");
   a_tick_pulse: assert property (baud_tick_ff |=> !baud_tick_ff)
      else $error("tick too long");
   a_clock_tick: assert property (bit_clock_ff |-> baud_tick_ff)
      else $error("bit clock without tick");
   a_clock_mode: assert property (baud_tick_ff && $stable(sh_ff[1][MASTER_BIT])
      |-> bit_clock_ff == sh_ff[1][MASTER_BIT])
      else $error("bit clock mode wrong");
   a_valid_pulse: assert property (rx_bit_valid_ff |=> !rx_bit_valid_ff)
      else $error("valid too long");
   a_vote_hold: assert property ($changed(rx_bit_ff) |-> rx_bit_valid_ff)
      else $error("bit changed without valid");
   a_bad_addr: assert property (apb_req.psel && apb_req.penable && apb_req.paddr > ADDR_STATUS |-> apb_rsp.pslverr)
      else $error("no error on unmapped");
endmodule
bind brg_top brg_monitor u_mon (.clock(clock), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .rx(rx),
   .baud_tick_ff(baud_tick_ff), .bit_clock_ff(bit_clock_ff), .rx_bit_ff(rx_bit_ff), .rx_bit_valid_ff(rx_bit_valid_ff));

// ### tb/tb.sv
// Bench for brg_top: registers, tick periods, timer clear, voter.
// Assumes a zero-wait APB slave; checker bound to the top.
`timescale 1ns/1ps
module tb;
   import brg_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic rx = 1'b1;
   logic tk, bc, rb, rv, e;
   logic [31:0] d;
   brg_apb_req_s rq = '0;
   brg_apb_rsp_s rs;
   int errors = 0;
   int samples_checked = 0;
   int n;
   logic [7:0] bt [6] = '{8'h0, 8'h0, 8'h8, 8'h8, 8'h0, 8'h8};
   logic [7:0] tt [6] = '{8'h80, 8'h4, 8'h0, 8'h84, 8'h94, 8'h90};
   int pt [6] = '{192, 48, 4144, 1036, 12, 1036};
   brg_top DUT (.clock(clock), .rst_n(rst_n), .apb_req(rq), .apb_rsp(rs), .rx(rx), .baud_tick_ff(tk),
      .bit_clock_ff(bc), .rx_bit_ff(rb), .rx_bit_valid_ff(rv));
   initial forever #2.5 clock = ~clock;
   initial begin
      #250us;
      errors++;
      complete_run();
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      samples_checked++;
      if (s !== x) begin
         errors++;
         $display("wrong value at %0t: saw %h wanted %h", $time, s, x);
      end
   endtask
   task automatic complete_run();
      $display("errors %0d of %0d checks", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      rq <= '{1'b1, 1'b0, w, a, v};
      @(posedge clock);
      rq.penable <= 1'b1;
      do @(posedge clock); while (rs.pready !== 1'b1);
      d = rs.prdata;
      e = rs.pslverr;
      rq <= '0;
      @(posedge clock);
   endtask
   // Clocks from the call up to the next tick
   task automatic tick(output int c);
      c = 0;
      do begin
         @(posedge clock);
         c++;
      end while (tk !== 1'b1);
   endtask
   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         chk(d, 32'h0);
      end
      apb(1'b0, 12'h020, 32'h0);
      chk(e, 32'h1);
      apb(1'b1, ADDR_BAUD_CONTROL, 32'hff);
      apb(1'b0, ADDR_BAUD_CONTROL, 32'h0);
      chk(d, {24'h0, BAUD_CONTROL_MASK});
      apb(1'b1, ADDR_TRANSMIT_CONTROL, 32'hff);
      apb(1'b0, ADDR_TRANSMIT_CONTROL, 32'h0);
      chk(d, {24'h0, TRANSMIT_CONTROL_MASK});
      chk(e, 32'h0);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, ADDR_BAUD_CONTROL, {24'h0, bt[i]});
         apb(1'b1, ADDR_TRANSMIT_CONTROL, {24'h0, tt[i]});
         apb(1'b1, ADDR_DIVISOR_LOW, 32'h2);
         apb(1'b1, ADDR_DIVISOR_HIGH, 32'h1);
         tick(n);
         tick(n);
         chk(n, pt[i]);
         chk(bc, tt[i][MASTER_BIT]);
      end
      apb(1'b1, ADDR_BAUD_CONTROL, 32'h0);
      apb(1'b1, ADDR_TRANSMIT_CONTROL, 32'h0);
      apb(1'b1, ADDR_DIVISOR_LOW, 32'hff);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(d, 32'hff);
      tick(n);
      repeat (100) @(posedge clock);
      apb(1'b1, ADDR_DIVISOR_LOW, 32'h0);
      tick(n);
      chk(32'(n > 57 && n < 67), 32'h1);
      rx <= 1'b0;
      repeat (2) @(posedge clock iff rv === 1'b1);
      chk(rb, 32'h0);
      rx <= 1'b1;
      repeat (2) @(posedge clock iff rv === 1'b1);
      chk(rb, 32'h1);
      complete_run();
   end
endmodule
